// ===== logic/itr_pkg.sv
package itr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ITR_OFS_CTRL = 8'h00;
  localparam logic [7:0] ITR_OFS_STAT = 8'h04;
  localparam logic [7:0] ITR_OFS_DATA = 8'h08;
  localparam logic [7:0] ITR_OFS_ADDR = 8'h0c;
  localparam logic [7:0] ITR_OFS_SLP  = 8'h10;
  // control register fields
  localparam int ITR_CB_DONE  = 7;
  localparam int ITR_CB_ACK   = 6;
  localparam int ITR_CB_BEGIN = 5;
  localparam int ITR_CB_HALT  = 4;
  localparam int ITR_CB_EN    = 2;
  // own address register fields
  localparam int ITR_AB_GCE   = 0;
  // reset values
  localparam logic [7:0] ITR_CTRL_RST = 8'h00;
  localparam logic [7:0] ITR_ADDR_RST = 8'h00;
  localparam logic [7:0] ITR_DATA_RST = 8'hff;
  // status codes, prescaler bits read zero
  localparam logic [7:0] ITR_ST_IDLE     = 8'hf8;
  localparam logic [7:0] ITR_ST_OWN_W    = 8'h60;
  localparam logic [7:0] ITR_ST_ARB_OWN  = 8'h68;
  localparam logic [7:0] ITR_ST_GC       = 8'h70;
  localparam logic [7:0] ITR_ST_ARB_GC   = 8'h78;
  localparam logic [7:0] ITR_ST_DATA_ACK = 8'h80;
  localparam logic [7:0] ITR_ST_DATA_NAK = 8'h88;
  localparam logic [7:0] ITR_ST_GC_ACK   = 8'h90;
  localparam logic [7:0] ITR_ST_GC_NAK   = 8'h98;
  localparam logic [7:0] ITR_ST_STOP     = 8'ha0;
  localparam logic [6:0] ITR_BCAST_ADDR  = 7'h00;
  // link side state machine
  typedef enum logic [2:0] {
    ITR_LK_IDLE = 3'b000,
    ITR_LK_ADDR = 3'b001,
    ITR_LK_AACK = 3'b010,
    ITR_LK_DATA = 3'b011,
    ITR_LK_DACK = 3'b100,
    ITR_LK_HOLD = 3'b101,
    ITR_LK_SKIP = 3'b110
  } itr_link_state_t;
  // two-wire pin triple
  typedef struct packed {
    logic i;
    logic o;
    logic oe;
  } itr_pin_t;
endpackage

// ===== logic/itr_target_rx.sv
`timescale 1ns/1ps
// Notes on behaviour
// - answer only when the top seven own-address bits match the received address, or to an enabled broadcast
// - own-address bit zero enables answering the broadcast address
// - after an address match, write direction receives; read direction is skipped here
// - own write address sets the completion flag with a valid status code
// - status 60 after own write address acknowledged
// - status 68 when addressed after lost arbitration as controller
// - status 70 after broadcast address acknowledged
// - status 78 for broadcast after lost arbitration
// - status 80 after acknowledged own-address data byte, byte readable in data register
// - clearing the flag receives next byte, acked per ack enable
// - status 88 after own-address data byte refused
// - leaving 88 enters not-addressed mode; recognition follows ack enable
// - ack enable cleared mid transfer refuses the next data byte
// - with ack enable zero the own address is not acknowledged
// - in deep sleep with ack enable set, address match still acknowledged, wake requested
// - after a sleep match the clock line is held low until the flag clears
// - data register need not hold the last bus byte after a sleep wake
module itr_target_rx
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // two-wire link pins
  input  wire itr_pkg::itr_pin_t scl_pin,
  input  wire itr_pkg::itr_pin_t sda_pin,
  output logic                   scl_o,
  output logic                   scl_oe,
  output logic                   sda_o,
  output logic                   sda_oe,
  // system hooks
  input  wire logic              arb_lost,
  output logic                   wake_req
);
  import itr_pkg::*;

  // pin synchronisers, first stage read only by the second
  logic [1:0] scl_sy_q, sda_sy_q;
  logic       scl_prev_q, sda_prev_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      scl_sy_q   <= 2'b11;
      sda_sy_q   <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sy_q   <= {scl_sy_q[0], scl_pin.i};
      sda_sy_q   <= {sda_sy_q[0], sda_pin.i};
      scl_prev_q <= scl_sy_q[1];
      sda_prev_q <= sda_sy_q[1];
    end

  // bus edge and condition detection
  wire scl_s   = scl_sy_q[1];
  wire sda_s   = sda_sy_q[1];
  wire scl_ris = scl_s & ~scl_prev_q;
  wire scl_fal = ~scl_s & scl_prev_q;
  wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // software visible registers, then internal bookkeeping and link state
  logic [7:0] ctrl_q, addr_q, data_q, stat_q;
  logic       sleep_q;
  logic       done_q;
  logic       arb_q;
  logic       gc_q;
  logic       recog_q;
  itr_link_state_t lk_q;
  logic [3:0] bit_q;
  logic [7:0] shf_q;
  logic       ack_q;

  // apb decode
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_ct  = paddr == ITR_OFS_CTRL;
  wire hit_st  = paddr == ITR_OFS_STAT;
  wire hit_dt  = paddr == ITR_OFS_DATA;
  wire hit_ad  = paddr == ITR_OFS_ADDR;
  wire hit_sl  = paddr == ITR_OFS_SLP;
  wire mapped  = hit_ct | hit_st | hit_dt | hit_ad | hit_sl;
  wire wr_ct   = wr & hit_ct;
  // writing one to the completion flag clears it
  wire flag_clr = wr_ct & pwdata[ITR_CB_DONE];
  wire en       = ctrl_q[ITR_CB_EN];
  wire ack_en   = ctrl_q[ITR_CB_ACK];

  // address recognition
  wire own_hit  = shf_q[7:1] == addr_q[7:1];
  wire gc_hit   = (shf_q[7:1] == ITR_BCAST_ADDR) & addr_q[ITR_AB_GCE];
  wire addr_ok  = en & ack_en & recog_q & (own_hit | gc_hit);
  wire is_write = ~shf_q[0];

  // event from the link to the software side
  logic       ev;
  logic [7:0] ev_code;
  wire  addr_ev = (lk_q == ITR_LK_AACK) & scl_fal & is_write & addr_ok;
  wire  data_ev = (lk_q == ITR_LK_DACK) & scl_fal;
  wire  stop_ev = stop_c & (lk_q == ITR_LK_DATA) & ~done_q;
  wire [7:0] code_addr = gc_hit & ~own_hit ? (arb_q ? ITR_ST_ARB_GC : ITR_ST_GC)
                                           : (arb_q ? ITR_ST_ARB_OWN : ITR_ST_OWN_W);
  wire [7:0] code_data = gc_q ? (ack_q ? ITR_ST_GC_ACK : ITR_ST_GC_NAK)
                              : (ack_q ? ITR_ST_DATA_ACK : ITR_ST_DATA_NAK);
  assign ev      = addr_ev | data_ev | stop_ev;
  assign ev_code = addr_ev ? code_addr : (data_ev ? code_data : ITR_ST_STOP);

  // control register; hardware set of the flag wins over the clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= ITR_CTRL_RST;
    else if (ev)
      ctrl_q <= (wr_ct ? {1'b0, pwdata[6:0]} : ctrl_q) | 8'h80;
    else if (wr_ct)
      ctrl_q <= {ctrl_q[7] & ~pwdata[7], pwdata[6:0]};
  assign done_q = ctrl_q[ITR_CB_DONE];

  // status, own address, sleep and arbitration bookkeeping
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stat_q  <= ITR_ST_IDLE;
      addr_q  <= ITR_ADDR_RST;
      sleep_q <= 1'b0;
      arb_q   <= 1'b0;
    end
    else
    begin
      if (ev)
        stat_q <= ev_code;
      else if (flag_clr && (stat_q == ITR_ST_DATA_NAK || stat_q == ITR_ST_GC_NAK
                            || stat_q == ITR_ST_STOP))
        stat_q <= ITR_ST_IDLE;
      if (wr && hit_ad)
        addr_q <= pwdata[7:0];
      if (wr && hit_sl)
        sleep_q <= pwdata[0];
      else if (addr_ev)
        sleep_q <= 1'b0;
      if (arb_lost)
        arb_q <= 1'b1;
      else if (addr_ev || start_c)
        arb_q <= 1'b0;
    end

  // recognition is dropped on leaving a refused-data state with ack clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      recog_q <= 1'b1;
    else if (flag_clr && (stat_q == ITR_ST_DATA_NAK || stat_q == ITR_ST_GC_NAK))
      recog_q <= pwdata[ITR_CB_ACK];
    else if (wr_ct && pwdata[ITR_CB_ACK] && !done_q)
      recog_q <= 1'b1;

  // byte data register, left stale when woken from sleep
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      data_q <= ITR_DATA_RST;
    else if (data_ev)
      data_q <= shf_q;
    else if (wr && hit_dt && !sleep_q)
      data_q <= pwdata[7:0];

  // link state machine
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lk_q  <= ITR_LK_IDLE;
      bit_q <= 4'h0;
      shf_q <= 8'h00;
      ack_q <= 1'b0;
      gc_q  <= 1'b0;
    end
    else if (!en || stop_c)
      lk_q <= ITR_LK_IDLE;
    else if (start_c)
    begin
      lk_q  <= ITR_LK_ADDR;
      bit_q <= 4'h0;
    end
    else
      case (lk_q)
        ITR_LK_ADDR, ITR_LK_DATA:
          if (scl_ris && !done_q)
          begin
            shf_q <= {shf_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fal && bit_q == 4'h8)
          begin
            bit_q <= 4'h0;
            if (lk_q == ITR_LK_ADDR)
            begin
              lk_q <= ITR_LK_AACK;
              gc_q <= gc_hit & ~own_hit;
            end
            else
            begin
              lk_q  <= ITR_LK_DACK;
              ack_q <= ack_en;
            end
          end
        ITR_LK_AACK:
          if (scl_fal)
            lk_q <= addr_ok & is_write ? ITR_LK_HOLD : ITR_LK_SKIP;
        ITR_LK_DACK:
          if (scl_fal)
            lk_q <= ack_q ? ITR_LK_HOLD : ITR_LK_SKIP;
        ITR_LK_HOLD:
          if (!done_q)
            lk_q <= ITR_LK_DATA;
        ITR_LK_SKIP:
          lk_q <= ITR_LK_SKIP;
        default:
          lk_q <= ITR_LK_IDLE;
      endcase

  // pin drivers: ack low during ack slot, clock held while flag set after an acked address or data byte
  wire drv_ack = ((lk_q == ITR_LK_AACK) & addr_ok & is_write)
               | ((lk_q == ITR_LK_DACK) & ack_q);
  wire hold_c  = (lk_q == ITR_LK_HOLD) & done_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sda_oe   <= 1'b0;
      scl_oe   <= 1'b0;
      sda_o    <= 1'b0;
      scl_o    <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      sda_oe   <= drv_ack & ~scl_s | drv_ack & sda_oe;
      scl_oe   <= hold_c;
      sda_o    <= 1'b0;                                                   // open drain, low only
      scl_o    <= 1'b0;
      wake_req <= sleep_q & addr_ev;
    end

  // apb read mux, single-cycle answer
  wire [7:0] rd_sel = hit_ct ? ctrl_q : hit_st ? stat_q : hit_dt ? data_q
                    : hit_ad ? addr_q : {7'h00, sleep_q};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= {24'h0, rd_sel};
    end

  // flag set shows the code of the event on the next cycle
  a_code_follows_ev: assert property (@(posedge pclk) disable iff (!presetn)
    addr_ev |=> done_q && (stat_q[7:4] == 4'h6 || stat_q[7:4] == 4'h7))
    else $error("address event did not raise flag and status");
  a_data_ack_code: assert property (@(posedge pclk) disable iff (!presetn)
    data_ev && ack_q && !gc_q |=> stat_q == 8'h80 && data_q == $past(shf_q))
    else $error("acked data byte status wrong");
  a_data_nak_code: assert property (@(posedge pclk) disable iff (!presetn)
    data_ev && !ack_q && !gc_q |=> stat_q == 8'h88)
    else $error("refused data byte status wrong");
  a_noack_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    lk_q == ITR_LK_AACK && !ack_en |=> !sda_oe)
    else $error("address acked with ack enable clear");
  a_hold_clock_low: assert property (@(posedge pclk) disable iff (!presetn)
    lk_q == ITR_LK_HOLD && done_q |=> scl_oe)
    else $error("clock not stretched while flag set");
  a_release_after: assert property (@(posedge pclk) disable iff (!presetn)
    lk_q == ITR_LK_HOLD && !done_q |=> ##1 !scl_oe)
    else $error("clock not released after flag cleared");
  a_ack_latched_en: assert property (@(posedge pclk) disable iff (!presetn)
    lk_q == ITR_LK_DATA && scl_fal && bit_q == 4'h8 && !stop_c && !start_c && en
      |=> !ack_q == !$past(ack_en))
    else $error("data ack does not follow ack enable");
  a_recog_dropped: assert property (@(posedge pclk) disable iff (!presetn)
    flag_clr && stat_q == ITR_ST_DATA_NAK && !pwdata[ITR_CB_ACK] |=> !recog_q)
    else $error("recognition kept after refused-data exit");
  a_own_gate: assert property (@(posedge pclk) disable iff (!presetn)
    addr_ev |-> own_hit || (shf_q[7:1] == 7'h00 && addr_q[0]))
    else $error("address event without match");
  a_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_q && addr_ev |=> wake_req ##1 !wake_req)
    else $error("wake request not pulsed");

  // named steps: an accepted write address in its ack slot, a cleared hold
  sequence s_own_slot;
    lk_q == ITR_LK_AACK && addr_ok && is_write && !scl_s;
  endsequence
  sequence s_hold_cleared;
    lk_q == ITR_LK_HOLD && !done_q;
  endsequence

  // the data line is pulled low for an accepted address
  a_addr_ack_drive: assert property (@(posedge pclk) disable iff (!presetn)
    s_own_slot |=> sda_oe)
    else $error("own address not acknowledged");
  // a cleared hold moves on to the next byte unless the frame ended
  a_hold_moves_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_hold_cleared |=> lk_q == ITR_LK_DATA || lk_q == ITR_LK_IDLE || lk_q == ITR_LK_ADDR)
    else $error("cleared hold did not resume reception");
  // every event raises the completion flag
  a_flag_raised: assert property (@(posedge pclk) disable iff (!presetn)
    ev |=> done_q)
    else $error("event did not raise the completion flag");
  // broadcast code without lost arbitration
  a_gc_code: assert property (@(posedge pclk) disable iff (!presetn)
    addr_ev && gc_hit && !own_hit && !arb_q |=> stat_q == ITR_ST_GC)
    else $error("broadcast status wrong");
  // own address after lost arbitration
  a_arb_own_code: assert property (@(posedge pclk) disable iff (!presetn)
    addr_ev && own_hit && arb_q |=> stat_q == ITR_ST_ARB_OWN)
    else $error("lost arbitration own status wrong");
  // a refused data byte leaves the data line released
  a_refuse_release: assert property (@(posedge pclk) disable iff (!presetn)
    lk_q == ITR_LK_DACK && !ack_q |=> !sda_oe)
    else $error("refused byte still acknowledged");
endmodule

// ===== verification/itr_ctl_model.sv
`timescale 1ns/1ps
// behavioural bus controller; both lines are open drain with pull-ups
module itr_ctl_model
(
  // wire levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // high means released
  output logic      scl_q,
  output logic      sda_q
);
  // clock stands still high outside frames
  initial
  begin
    scl_q = 1'b1;
    sda_q = 1'b1;
  end
  // release the clock and wait while the target stretches it
  task automatic rise();
    int n;
    scl_q = 1'b1;
    n = 0;
    while (scl_w !== 1'b1 && n < 20000)
    begin
      #4;
      n++;
    end
    #16;
  endtask
  // one bit: data moves only while the clock is low
  task automatic pulse(input logic v, output logic s);
    sda_q = v;
    #16;
    rise();
    s = sda_w;
    #16;
    scl_q = 1'b0;
    #16;
  endtask
  // start: data falls while the clock is high
  task automatic start();
    sda_q = 1'b1;
    #16;
    rise();
    sda_q = 1'b0;
    #16;
    scl_q = 1'b0;
  endtask
  // byte msb first, then the ack slot with data released
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      pulse(b[i], ack);
    pulse(1'b1, ack);
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_q = 1'b0;
    #16;
    rise();
    sda_q = 1'b1;
    #16;
  endtask
endmodule

// ===== verification/itr_target_rx_tb.sv
`timescale 1ns/1ps
module itr_target_rx_tb;
  import itr_pkg::*;
  logic              pclk;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              arb_lost = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       seed = 32'd88;
  logic              wake_seen = 1'b0;
  int                n_mismatch = 0;
  int                comparisons = 0;
  int                cyc = 0;
  wire logic         pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake_req;
  wire logic         scl_q, sda_q, scl_w, sda_w;
  wire logic  [31:0] prdata;
  itr_pin_t          scl_p;
  itr_pin_t          sda_p;
  localparam logic [7:0] OFS [5] = '{ITR_OFS_CTRL, ITR_OFS_STAT, ITR_OFS_DATA, ITR_OFS_ADDR,
                                     ITR_OFS_SLP};
  localparam logic [7:0] RSTV [5] = '{ITR_CTRL_RST, ITR_ST_IDLE, ITR_DATA_RST, ITR_ADDR_RST,
                                      8'h00};
  // wired-and levels with pull-ups
  assign scl_w = scl_q & ~(scl_oe & ~scl_o);
  assign sda_w = sda_q & ~(sda_oe & ~sda_o);
  assign scl_p = {scl_w, 2'b00};
  assign sda_p = {sda_w, 2'b00};
  itr_target_rx itr_target_rx_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .scl_pin(scl_p), .sda_pin(sda_p), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost),
    .wake_req(wake_req));
  itr_ctl_model itr_ctl_model_i (.scl_w(scl_w), .sda_w(sda_w), .scl_q(scl_q), .sda_q(sda_q));
  // clock source
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // run length limit and wake pulse catcher
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) wake_seen <= 1'b1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 8'h00, r, e);
  endtask
  // bounded poll of the flag, then status with prescaler bits masked
  task automatic st(input logic [7:0] exp);
    logic [31:0] r;
    for (int i = 0; i < 6; i++)
    begin
      rd(ITR_OFS_CTRL, r);
      if (r[ITR_CB_DONE] === 1'b1) break;
    end
    rd(ITR_OFS_STAT, r);
    chk("status", r & 32'hf8, {24'h0, exp});
  endtask
  // start plus address byte; ack is the expected data level in the slot
  task automatic frame(input logic [7:0] b, input logic ack, input logic [7:0] exp);
    logic a;
    itr_ctl_model_i.start();
    itr_ctl_model_i.put(b, a);
    chk("address ack", {31'h0, a}, {31'h0, ack});
    st(exp);
  endtask
  // random byte acknowledged and readable
  task automatic dbyte();
    logic [31:0] v;
    logic [31:0] r;
    logic        a;
    v = rnd();
    wr(ITR_OFS_CTRL, 8'hc4);
    itr_ctl_model_i.put(v[7:0], a);
    chk("data ack", {31'h0, a}, 32'h0);
    st(ITR_ST_DATA_ACK);
    rd(ITR_OFS_DATA, r);
    chk("data", r, {24'h0, v[7:0]});
  endtask
  // byte refused after ack enable cleared, then leave with ctl and stop
  task automatic drop(input logic [7:0] exp, input logic [7:0] ctl);
    logic [31:0] v;
    logic        a;
    v = rnd();
    wr(ITR_OFS_CTRL, 8'h84);
    itr_ctl_model_i.put(v[7:0], a);
    chk("refused ack", {31'h0, a}, 32'h1);
    st(exp);
    wr(ITR_OFS_CTRL, ctl);
    itr_ctl_model_i.stop();
  endtask
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [6:0]  own;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(OFS[i], r);
      chk("reset value", r, {24'h0, RSTV[i]});
    end
    apb(1'b0, 8'h14, 8'h5a, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    r = rnd();
    own = {1'b1, r[5:0]};
    wr(ITR_OFS_ADDR, {own, 1'b1});
    wr(ITR_OFS_CTRL, 8'h44);
    frame({own, 1'b0}, 1'b0, ITR_ST_OWN_W);
    chk("stretch", {31'h0, scl_oe}, 32'h1);
    repeat (3) dbyte();
    drop(ITR_ST_DATA_NAK, 8'h84);
    frame({own, 1'b0}, 1'b1, ITR_ST_IDLE);
    itr_ctl_model_i.stop();
    wr(ITR_OFS_CTRL, 8'h44);
    frame({own, 1'b0}, 1'b0, ITR_ST_OWN_W);
    drop(ITR_ST_DATA_NAK, 8'hc4);
    frame({own ^ 7'h01, 1'b0}, 1'b1, ITR_ST_IDLE);
    itr_ctl_model_i.stop();
    frame({own, 1'b1}, 1'b1, ITR_ST_IDLE);
    itr_ctl_model_i.stop();
    // broadcast without and with its enable, then lost arbitration cases
    for (int g = 0; g < 2; g++)
    begin
      wr(ITR_OFS_ADDR, {own, g[0]});
      frame(8'h00, ~g[0], g[0] ? ITR_ST_GC : ITR_ST_IDLE);
      if (g == 1) drop(ITR_ST_GC_NAK, 8'hc4);
      else itr_ctl_model_i.stop();
    end
    for (int g = 0; g < 2; g++)
    begin
      logic a;
      // arbitration is lost inside the frame, after its start condition
      itr_ctl_model_i.start();
      @(posedge pclk);
      arb_lost <= 1'b1;
      @(posedge pclk);
      arb_lost <= 1'b0;
      itr_ctl_model_i.put(g[0] ? 8'h00 : {own, 1'b0}, a);
      chk("arb address ack", {31'h0, a}, 32'h0);
      st(g[0] ? ITR_ST_ARB_GC : ITR_ST_ARB_OWN);
      drop(g[0] ? ITR_ST_GC_NAK : ITR_ST_DATA_NAK, 8'hc4);
    end
    // match in deep sleep: wake pulse, clock held until the flag clears
    wr(ITR_OFS_SLP, 8'h01);
    frame({own, 1'b0}, 1'b0, ITR_ST_OWN_W);
    chk("wake", {31'h0, wake_seen}, 32'h1);
    wr(ITR_OFS_SLP, 8'h00);
    chk("held clock", {31'h0, scl_oe}, 32'h1);
    dbyte();
    drop(ITR_ST_DATA_NAK, 8'hc4);
    stop_test();
  end
endmodule
